/* File: design/lics_defines.vh */
// Constants of the charge state sequencer: register offsets, field positions,
// reset values and timer limits. Included by the sequencer, its checker and its bench.
// How it works
// - Start disabled with no charge current while supply ramps up.
// - Disabled to pre-qualification once supply valid and enable active.
// - Pre-qualification uses low current; leave for charge when battery above 3V.
// - Pre-qualification timer expiry enters fault state and stops charging.
// - Pre-qualification suspends into over-temperature when temperature out of range.
// - Charge state selects ten times the pre-qualification current level.
// - Charge state suspends into over-temperature when temperature out of range.
// - Charge moves to top-off when current falls to 7.5 percent.
// - Top-off holds voltage and top-off current for the timer duration.
// - Top-off timer expiry enters done with zero battery current.
// - Done returns to charge when battery falls below 4.05V.
// - No valid power: power-good flag high, disabled from any state.
// - Charging indicator low in charge, high in pre-qual/top-off, held when suspended.
// - Fault flag latches; clears only by power cycle or enable toggle. The code also clears it when the control enable bit is written 0.
// - State timer freezes while suspended for temperature, resumes afterwards.
`ifndef LICS_DEFINES_VH
`define LICS_DEFINES_VH

// ==========================================================
// Register offsets
`define LICS_OFS_CTRL       8'h00
`define LICS_OFS_STATUS     8'h04
`define LICS_OFS_IRQ_STAT   8'h08
`define LICS_OFS_IRQ_MASK   8'h0C
`define LICS_OFS_PREQ_LIM   8'h10
`define LICS_OFS_CHG_LIM    8'h14
`define LICS_OFS_TOP_LIM    8'h18
`define LICS_OFS_TIMER      8'h1C

// ==========================================================
// Field positions
`define LICS_CTRL_EN_BIT    0
`define LICS_ST_STATE_LSB   0
`define LICS_ST_STATE_MSB   6
`define LICS_ST_LEVEL_LSB   8
`define LICS_ST_LEVEL_MSB   9
`define LICS_ST_PGOOD_BIT   12
`define LICS_ST_CHGIND_BIT  13
`define LICS_ST_FAULT_BIT   14
`define LICS_IRQ_CHANGE     0
`define LICS_IRQ_FAULT      1
`define LICS_IRQ_DONE       2
`define LICS_IRQ_OVERTEMP   3
`define LICS_IRQ_PWRLOST    4
`define LICS_IRQ_W          5

// ==========================================================
// Charge current level select codes
`define LICS_LVL_OFF        2'h0
`define LICS_LVL_PREQ       2'h1
`define LICS_LVL_FULL       2'h2
`define LICS_LVL_TOPOFF     2'h3

// ==========================================================
// Reset values; limits count timer capacitor ticks
`define LICS_RST_CTRL       1'h1
`define LICS_RST_IRQ_MASK   5'h00
`define LICS_RST_PREQ_LIM   16'h015C
`define LICS_RST_CHG_LIM    16'h0D0C
`define LICS_RST_TOP_LIM    16'h015C

`endif

/* File: design/lics_seq_top.v */
// Charge state sequencer of a single-cell linear charger, with register port.
// Assumes comparator inputs and timer ticks are synchronous to clock.
`timescale 1ns/1ps
`include "lics_defines.vh"

module lics_seq_top #(
	parameter TW = 16
) (
	input  wire        clock,
	input  wire        rst_b,
	input  wire        ce,
	input  wire        supply_valid,
	input  wire        enable,
	input  wire        batt_above_prequal,
	input  wire        batt_below_recharge,
	input  wire        current_below_taper,
	input  wire        temp_in_range,
	input  wire        timer_capacitor_input,
	input  wire [7:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	output reg  [1:0]  current_level,
	output reg         power_good_flag_b,
	output reg         charging_indicator_b,
	output reg         fault_flag_b,
	output reg         over_temperature_suspend,
	output reg         irq
);

	// ==========================================================
	// States
	localparam S_DIS  = 7'b0000001;
	localparam S_PREQ = 7'b0000010;
	localparam S_CHG  = 7'b0000100;
	localparam S_TOP  = 7'b0001000;
	localparam S_DONE = 7'b0010000;
	localparam S_OT   = 7'b0100000;
	localparam S_FLT  = 7'b1000000;

	reg  [6:0]              state_r;
	reg  [6:0]              state_nxt;
	reg                     resume_chg_r;
	reg                     resume_chg_nxt;
	reg                     sw_en_r;
	reg  [`LICS_IRQ_W-1:0]  irq_stat_r;
	reg  [`LICS_IRQ_W-1:0]  irq_stat_nxt;
	reg  [`LICS_IRQ_W-1:0]  irq_mask_r;
	reg  [`LICS_IRQ_W-1:0]  irq_ev;
	reg  [TW-1:0]           preq_lim_r;
	reg  [TW-1:0]           chg_lim_r;
	reg  [TW-1:0]           top_lim_r;
	reg  [TW-1:0]           limit;
	reg  [1:0]              level_nxt;
	reg                     chg_ind_nxt;
	reg                     fault_nxt;
	reg  [31:0]             rdata_nxt;
	wire                    run_ok;
	wire                    restart;
	wire                    timer_run;
	wire                    expired;
	wire [TW-1:0]           timer_count;
	wire                    stat_read;

	// Both the pin and the control bit must be active to leave disabled
	assign run_ok = supply_valid && enable && sw_en_r;

	// ==========================================================
	// Next-state logic
	always @*
	begin
		state_nxt = state_r;
		resume_chg_nxt = resume_chg_r;
		if (!run_ok)
			state_nxt = S_DIS;
		else
		begin
			case (state_r)
			S_DIS:
				state_nxt = S_PREQ;
			S_PREQ:
			begin
				if (!temp_in_range)
				begin
					state_nxt = S_OT;
					resume_chg_nxt = 1'b0;
				end
				else if (batt_above_prequal)
					state_nxt = S_CHG;
				else if (expired)
					state_nxt = S_FLT;
			end
			S_CHG:
			begin
				if (!temp_in_range)
				begin
					state_nxt = S_OT;
					resume_chg_nxt = 1'b1;
				end
				else if (current_below_taper)
					state_nxt = S_TOP;
				else if (expired)
					state_nxt = S_FLT;
			end
			S_TOP:
				if (expired)
					state_nxt = S_DONE;
			S_DONE:
				if (batt_below_recharge)
					state_nxt = S_CHG;
			S_OT:
				if (temp_in_range)
					state_nxt = resume_chg_r ? S_CHG : S_PREQ;
			S_FLT:
				state_nxt = S_FLT;
			default:
				state_nxt = S_DIS;
			endcase
		end
	end

	// ==========================================================
	// Timer control: fresh count on real entry, frozen while suspended
	assign restart = (state_nxt != state_r) && (state_r != S_OT) &&
		((state_nxt == S_PREQ) || (state_nxt == S_CHG) || (state_nxt == S_TOP));
	assign timer_run = timer_capacitor_input &&
		((state_r == S_PREQ) || (state_r == S_CHG) || (state_r == S_TOP));

	always @*
	begin
		case (state_r)
		S_CHG:   limit = chg_lim_r;
		S_TOP:   limit = top_lim_r;
		default: limit = preq_lim_r;
		endcase
	end

	lics_state_timer #(
		.WIDTH   (TW)
	) u_timer (
		.clock   (clock),
		.rst_b   (rst_b),
		.ce      (ce),
		.restart (restart),
		.run     (timer_run),
		.limit   (limit),
		.count   (timer_count),
		.expired (expired)
	);

	// ==========================================================
	// Output values derived from the next state
	always @*
	begin
		level_nxt = `LICS_LVL_OFF;
		chg_ind_nxt = 1'b1;
		fault_nxt = 1'b0;
		case (state_nxt)
		S_PREQ:  level_nxt = `LICS_LVL_PREQ;
		S_CHG:   level_nxt = `LICS_LVL_FULL;
		S_TOP:   level_nxt = `LICS_LVL_TOPOFF;
		default: level_nxt = `LICS_LVL_OFF;
		endcase
		case (state_nxt)
		S_CHG:   chg_ind_nxt = 1'b0;
		S_OT:    chg_ind_nxt = charging_indicator_b;
		default: chg_ind_nxt = 1'b1;
		endcase
		// Latched until the sequencer is sent back to disabled
		fault_nxt = (state_nxt == S_FLT);
	end

	// ==========================================================
	// Interrupt events
	assign stat_read = rd && (addr == `LICS_OFS_IRQ_STAT);

	always @*
	begin
		irq_ev = {`LICS_IRQ_W{1'b0}};
		irq_ev[`LICS_IRQ_CHANGE]   = (state_nxt != state_r);
		irq_ev[`LICS_IRQ_FAULT]    = (state_nxt == S_FLT) && (state_r != S_FLT);
		irq_ev[`LICS_IRQ_DONE]     = (state_nxt == S_DONE) && (state_r != S_DONE);
		irq_ev[`LICS_IRQ_OVERTEMP] = (state_nxt == S_OT) && (state_r != S_OT);
		irq_ev[`LICS_IRQ_PWRLOST]  = !supply_valid && !power_good_flag_b;
		// A new event in the read cycle survives the clear
		irq_stat_nxt = (stat_read ? {`LICS_IRQ_W{1'b0}} : irq_stat_r) | irq_ev;
	end

	// ==========================================================
	// Register read mux; unmapped offsets read zero
	always @*
	begin
		rdata_nxt = 32'h0000_0000;
		case (addr)
		`LICS_OFS_CTRL:     rdata_nxt[`LICS_CTRL_EN_BIT] = sw_en_r;
		`LICS_OFS_STATUS:
		begin
			rdata_nxt[`LICS_ST_STATE_MSB:`LICS_ST_STATE_LSB] = state_r;
			rdata_nxt[`LICS_ST_LEVEL_MSB:`LICS_ST_LEVEL_LSB] = current_level;
			rdata_nxt[`LICS_ST_PGOOD_BIT]  = power_good_flag_b;
			rdata_nxt[`LICS_ST_CHGIND_BIT] = charging_indicator_b;
			rdata_nxt[`LICS_ST_FAULT_BIT]  = fault_flag_b;
		end
		`LICS_OFS_IRQ_STAT: rdata_nxt[`LICS_IRQ_W-1:0] = irq_stat_r;
		`LICS_OFS_IRQ_MASK: rdata_nxt[`LICS_IRQ_W-1:0] = irq_mask_r;
		`LICS_OFS_PREQ_LIM: rdata_nxt[TW-1:0] = preq_lim_r;
		`LICS_OFS_CHG_LIM:  rdata_nxt[TW-1:0] = chg_lim_r;
		`LICS_OFS_TOP_LIM:  rdata_nxt[TW-1:0] = top_lim_r;
		`LICS_OFS_TIMER:    rdata_nxt[TW-1:0] = timer_count;
		default:            rdata_nxt = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// Registers
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= S_DIS;
			resume_chg_r <= 1'b0;
			sw_en_r <= `LICS_RST_CTRL;
			irq_stat_r <= {`LICS_IRQ_W{1'b0}};
			irq_mask_r <= `LICS_RST_IRQ_MASK;
			preq_lim_r <= `LICS_RST_PREQ_LIM;
			chg_lim_r <= `LICS_RST_CHG_LIM;
			top_lim_r <= `LICS_RST_TOP_LIM;
			rdata <= 32'h0000_0000;
			current_level <= `LICS_LVL_OFF;
			power_good_flag_b <= 1'b1;
			charging_indicator_b <= 1'b1;
			fault_flag_b <= 1'b1;
			over_temperature_suspend <= 1'b0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			resume_chg_r <= resume_chg_nxt;
			irq_stat_r <= irq_stat_nxt;
			current_level <= level_nxt;
			power_good_flag_b <= !supply_valid;
			charging_indicator_b <= chg_ind_nxt;
			fault_flag_b <= !fault_nxt;
			over_temperature_suspend <= (state_nxt == S_OT);
			irq <= |(irq_stat_nxt & irq_mask_r);
			rdata <= rd ? rdata_nxt : 32'h0000_0000;
			if (wr)
			begin
				case (addr)
				`LICS_OFS_CTRL:     sw_en_r <= wdata[`LICS_CTRL_EN_BIT];
				`LICS_OFS_IRQ_MASK: irq_mask_r <= wdata[`LICS_IRQ_W-1:0];
				`LICS_OFS_PREQ_LIM: preq_lim_r <= wdata[TW-1:0];
				`LICS_OFS_CHG_LIM:  chg_lim_r <= wdata[TW-1:0];
				`LICS_OFS_TOP_LIM:  top_lim_r <= wdata[TW-1:0];
				default:            sw_en_r <= sw_en_r;
				endcase
			end
		end
	end

endmodule // lics_seq_top

/* File: design/lics_state_timer.v */
// State timer: counts timer capacitor ticks up to a limit.
// Assumes restart and run come from the sequencer in the same clock domain.
`timescale 1ns/1ps

module lics_state_timer #(
	parameter WIDTH = 16
) (
	input  wire             clock,
	input  wire             rst_b,
	input  wire             ce,
	input  wire             restart,
	input  wire             run,
	input  wire [WIDTH-1:0] limit,
	output wire [WIDTH-1:0] count,
	output wire             expired
);

	reg [WIDTH-1:0] count_r;

	// ==========================================================
	// Counter; saturates so a stale expiry cannot wrap back
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			count_r <= {WIDTH{1'b0}};
		else if (ce)
		begin
			if (restart)
				count_r <= {WIDTH{1'b0}};
			else if (run && !expired)
				count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign count   = count_r;
	assign expired = (count_r >= limit);

endmodule // lics_state_timer

/* File: test/lics_cell_model.sv */
// Cell and thermistor model: turns a cell voltage and a hot flag into comparator levels.
// Assumes the bench sets volt_mv and hot just after a rising clock edge.
`timescale 1ns/1ps
// ==========================================================
// Cell model
module lics_cell_model (
	input  wire  clock,
	input  int   volt_mv,
	input  wire  hot,
	output logic batt_above_prequal,
	output logic batt_below_recharge,
	output logic current_below_taper,
	output logic temp_in_range
);
	// Comparators sample once per clock, so every level lags the cell by one edge
	always @(posedge clock)
	begin
		batt_above_prequal <= (volt_mv > 3000);
		batt_below_recharge <= (volt_mv < 4050);
		current_below_taper <= (volt_mv >= 4200);
		temp_in_range <= !hot;
	end
endmodule // lics_cell_model

/* File: test/lics_seq_top_assertions.sv */
// Port assertions of the charge sequencer.
// Assumes the software enable bit stays set for the whole run.
`timescale 1ns/1ps
`include "lics_defines.vh"
// ==========================================================
// Checker
module lics_seq_chk (
	input wire       clock,
	input wire       rst_b,
	input wire       ce,
	input wire       supply_valid,
	input wire       enable,
	input wire       batt_above_prequal,
	input wire       current_below_taper,
	input wire       temp_in_range,
	input wire [1:0] current_level,
	input wire       power_good_flag_b,
	input wire       charging_indicator_b,
	input wire       fault_flag_b,
	input wire       over_temperature_suspend
);
	wire run = ce && supply_valid && enable;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	pgood_track_a: assert property (ce |=> power_good_flag_b == !$past(supply_valid))
		else $error("power good flag wrong");
	no_power_off_a: assert property (ce && !supply_valid |=> current_level == `LICS_LVL_OFF)
		else $error("current on without power");
	prequal_go_a: assert property (run && temp_in_range && batt_above_prequal
		&& current_level == `LICS_LVL_PREQ |=> current_level == `LICS_LVL_FULL)
		else $error("prequal did not move to charge");
	ot_entry_a: assert property (run && !temp_in_range && !over_temperature_suspend
		&& current_level inside {`LICS_LVL_PREQ, `LICS_LVL_FULL} |=> over_temperature_suspend)
		else $error("no suspend on bad temperature");
	ot_resume_a: assert property (run && temp_in_range && over_temperature_suspend
		|=> !over_temperature_suspend && current_level inside {`LICS_LVL_PREQ, `LICS_LVL_FULL})
		else $error("no resume after suspend");
	taper_go_a: assert property (run && temp_in_range && current_below_taper
		&& current_level == `LICS_LVL_FULL |=> current_level == `LICS_LVL_TOPOFF && charging_indicator_b)
		else $error("no top-off on taper");
	chg_ind_a: assert property (current_level == `LICS_LVL_FULL |-> !charging_indicator_b)
		else $error("indicator high while charging");
	ot_hold_a: assert property (over_temperature_suspend && $past(over_temperature_suspend)
		|-> $stable(charging_indicator_b))
		else $error("indicator moved during suspend");
	fault_latch_a: assert property (!fault_flag_b && run |=> !fault_flag_b)
		else $error("fault flag dropped");
	fault_stop_a: assert property (!fault_flag_b |-> current_level == `LICS_LVL_OFF)
		else $error("current on in fault");
endmodule // lics_seq_chk

/* File: test/lics_seq_top_tb_top.sv */
// Bench: runs the sequencer through fault, charge, suspend, top-off and power loss.
// Assumes the cell model stands in for battery and thermistor.
`timescale 1ns/1ps
`include "lics_defines.vh"
// ==========================================================
// Bench top
module lics_seq_top_tb_top;
	logic        clock = 1'b0, rst_b = 1'b0, supply_valid = 1'b0, enable = 1'b1, hot = 1'b0;
	logic        timer_tick = 1'b0, wr = 1'b0, rd = 1'b0, rd_q1 = 1'b0, ce = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, pl, tl;
	logic [31:0] expq[$];
	int          volt_mv = 2500, n_mismatch = 0, comparisons = 0, cyc = 0, gap = 0;
	wire  [31:0] rdata;
	wire  [1:0]  current_level;
	wire         pg_b, chg_b, flt_b, ot, irq, above, below, taper, tin;
	initial
	begin
		forever #2.5 clock = ~clock;
	end
	lics_seq_top #(.TW(16)) lics_seq_top_inst (.clock(clock), .rst_b(rst_b), .ce(ce),
		.supply_valid(supply_valid), .enable(enable), .batt_above_prequal(above),
		.batt_below_recharge(below), .current_below_taper(taper), .temp_in_range(tin),
		.timer_capacitor_input(timer_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .current_level(current_level), .power_good_flag_b(pg_b),
		.charging_indicator_b(chg_b), .fault_flag_b(flt_b), .over_temperature_suspend(ot),
		.irq(irq));
	lics_cell_model lics_cell_model_inst (.clock(clock), .volt_mv(volt_mv), .hot(hot),
		.batt_above_prequal(above), .batt_below_recharge(below),
		.current_below_taper(taper), .temp_in_range(tin));
	// ==========================================================
	// Timer ticks at random spacing, and the hang limit
	always @(posedge clock)
	begin
		timer_tick <= (gap == 0);
		gap <= (gap == 0) ? int'($urandom_range(3, 0)) : gap - 1;
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch++;
			wrap_up;
		end
	end
	// Read data stand only in the cycle after the strobe
	always @(posedge clock)
	begin
		if (rd_q1)
			cmp(rdata, expq.pop_front());
		rd_q1 <= rd;
	end
	// ==========================================================
	// Tasks
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
	begin
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task automatic cmp_pin(input logic got, input logic exp);
	begin
		cmp({31'h0000_0000, got}, {31'h0000_0000, exp});
	end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
	begin
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	end
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
	begin
		expq.push_back(e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
	end
	endtask
	// Bounded wait; a wait that runs out shows up as a level mismatch
	task automatic wait_lvl(input logic [1:0] l);
		int i;
	begin
		for (i = 0; i < 400 && current_level !== l; i++)
			@(posedge clock);
		cmp({30'h0000_0000, current_level}, {30'h0000_0000, l});
	end
	endtask
	task automatic idle(input int n);
	begin
		repeat (n) @(posedge clock);
	end
	endtask
	task automatic wrap_up;
	begin
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	// ==========================================================
	// Tests
	initial
	begin
		void'($urandom(71053));
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		wr_reg(`LICS_OFS_STATUS, 32'hFFFF_FFFF);
		wr_reg(8'h20, 32'hFFFF_FFFF);
		rd_reg(`LICS_OFS_CTRL, 32'h0000_0001);
		rd_reg(`LICS_OFS_IRQ_MASK, 32'h0000_0000);
		rd_reg(`LICS_OFS_CHG_LIM, 32'h0000_0D0C);
		rd_reg(`LICS_OFS_TOP_LIM, 32'h0000_015C);
		rd_reg(8'h20, 32'h0000_0000);
		rd_reg(`LICS_OFS_STATUS, 32'h0000_7001);
		$display("test reset done");
		// Short limits keep the run brief; charge limit long enough to outlast a resume
		pl = $urandom_range(5, 2);
		tl = $urandom_range(12, 8);
		wr_reg(`LICS_OFS_PREQ_LIM, pl);
		wr_reg(`LICS_OFS_TOP_LIM, tl);
		wr_reg(`LICS_OFS_CHG_LIM, 32'h0000_0014);
		rd_reg(`LICS_OFS_PREQ_LIM, pl);
		wr_reg(`LICS_OFS_IRQ_MASK, 32'h0000_001F);
		supply_valid <= 1'b1;
		wait_lvl(`LICS_LVL_PREQ);
		wait_lvl(`LICS_LVL_OFF);
		idle(2);
		cmp({31'h0000_0000, irq}, 32'h0000_0001);
		rd_reg(`LICS_OFS_STATUS, 32'h0000_2040);
		cmp_pin(flt_b, 1'b0);
		rd_reg(`LICS_OFS_IRQ_STAT, 32'h0000_0003);
		idle(3);
		cmp({31'h0000_0000, irq}, 32'h0000_0000);
		$display("test prequal timeout done");
		wr_reg(`LICS_OFS_IRQ_MASK, 32'h0000_0000);
		enable <= 1'b0;
		idle(3);
		rd_reg(`LICS_OFS_STATUS, 32'h0000_6001);
		cmp_pin(flt_b, 1'b1);
		cmp({31'h0000_0000, irq}, 32'h0000_0000);
		rd_reg(`LICS_OFS_IRQ_STAT, 32'h0000_0001);
		wr_reg(`LICS_OFS_IRQ_MASK, 32'h0000_001F);
		$display("test enable toggle done");
		volt_mv <= 3700;
		enable <= 1'b1;
		wait_lvl(`LICS_LVL_FULL);
		cmp_pin(chg_b, 1'b0);
		hot <= 1'b1;
		// Far more ticks than the charge limit pass here, so a running timer would fault
		idle(120);
		rd_reg(`LICS_OFS_STATUS, 32'h0000_4020);
		cmp_pin(ot, 1'b1);
		hot <= 1'b0;
		idle(3);
		rd_reg(`LICS_OFS_STATUS, 32'h0000_4204);
		cmp_pin(ot, 1'b0);
		$display("test suspend done");
		volt_mv <= 4200;
		wait_lvl(`LICS_LVL_TOPOFF);
		rd_reg(`LICS_OFS_STATUS, 32'h0000_6308);
		wait_lvl(`LICS_LVL_OFF);
		rd_reg(`LICS_OFS_STATUS, 32'h0000_6010);
		volt_mv <= 4000;
		wait_lvl(`LICS_LVL_FULL);
		rd_reg(`LICS_OFS_IRQ_STAT, 32'h0000_000D);
		$display("test top-off done");
		supply_valid <= 1'b0;
		idle(3);
		rd_reg(`LICS_OFS_STATUS, 32'h0000_7001);
		cmp_pin(pg_b, 1'b1);
		rd_reg(`LICS_OFS_IRQ_STAT, 32'h0000_0011);
		idle(3);
		$display("test power loss done");
		// Clock enable low: a returning supply must not move the frozen sequencer
		ce <= 1'b0;
		supply_valid <= 1'b1;
		volt_mv <= 2500;
		hot <= 1'b1;
		idle(4);
		cmp_pin(pg_b, 1'b1);
		cmp_pin(ot, 1'b0);
		ce <= 1'b1;
		idle(3);
		rd_reg(`LICS_OFS_STATUS, 32'h0000_6020);
		cmp_pin(ot, 1'b1);
		hot <= 1'b0;
		wait_lvl(`LICS_LVL_PREQ);
		cmp_pin(chg_b, 1'b1);
		wait_lvl(`LICS_LVL_OFF);
		cmp_pin(flt_b, 1'b0);
		$display("test prequal suspend done");
		wrap_up;
	end
endmodule // lics_seq_top_tb_top

bind lics_seq_top lics_seq_chk lics_seq_chk_inst (.clock(clock), .rst_b(rst_b), .ce(ce),
	.supply_valid(supply_valid), .enable(enable), .batt_above_prequal(batt_above_prequal),
	.current_below_taper(current_below_taper), .temp_in_range(temp_in_range),
	.current_level(current_level), .power_good_flag_b(power_good_flag_b),
	.charging_indicator_b(charging_indicator_b), .fault_flag_b(fault_flag_b),
	.over_temperature_suspend(over_temperature_suspend));
